// ### rtl/irq_prio_pkg.sv
// constants, source map and level decode for the priority-level bank
package irq_prio_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 32;
  localparam int NUM_DBG = 5;
  localparam int NUM_PRIO = 6;
  localparam int ADDR_W = 8;
  localparam int NUM_EV = 3;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_PRIO0 = 6'h00;
  localparam logic [5:0] IDX_PRIO1 = 6'h01;
  localparam logic [5:0] IDX_PRIO2 = 6'h02;
  localparam logic [5:0] IDX_PRIO3 = 6'h03;
  localparam logic [5:0] IDX_PRIO4 = 6'h04;
  localparam logic [5:0] IDX_PRIO5 = 6'h05;
  localparam logic [5:0] IDX_STATUS = 6'h08;
  localparam logic [5:0] IDX_MASK = 6'h09;
  localparam logic [5:0] IDX_ACTIVE = 6'h0A;

  // ----------------------------------------------------------------
  // reset values and implemented-bit masks
  // ----------------------------------------------------------------
  localparam logic [15:0] PRIO_RESET = 16'h0000;
  localparam logic [NUM_EV-1:0] EV_RESET = 3'h0;
  localparam logic [15:0] IMPL_MASK [NUM_PRIO] = '{16'h3C00, 16'h003F, 16'hFFCF,
                                                  16'hFFFC, 16'hFC3F, 16'hFF3F};

  // ----------------------------------------------------------------
  // event bits of status and mask
  // ----------------------------------------------------------------
  localparam int EV_FWD = 0;
  localparam int EV_BLOCKED = 1;
  localparam int EV_DROPPED = 2;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // source to register and 2-bit slot (bits 2*slot+1:2*slot)
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_REG [NUM_SRC] = '{
    3'h0, 3'h0, 3'h1, 3'h1, 3'h1,
    3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2,
    3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3,
    3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4,
    3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5};
  localparam logic [2:0] SRC_SLOT [NUM_SRC] = '{
    3'h6, 3'h5, 3'h2, 3'h1, 3'h0,
    3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h1, 3'h0,
    3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1,
    3'h7, 3'h6, 3'h5, 3'h2, 3'h1, 3'h0,
    3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};

  // field to {enabled, level}
  function automatic logic [2:0] field_decode(input logic [1:0] field, input logic debug);
    if (field == 2'h0) begin
      return 3'h0;
    end else if (debug) begin
      return {1'b1, field};
    end else begin
      return {1'b1, 2'(field - 2'h1)};
    end
  endfunction

endpackage

// ### rtl/arb_if.sv
// carrier between the register bank and the level arbiter
`timescale 1ns/1ps
interface arb_if;
  import irq_prio_pkg::*;
  logic [NUM_SRC-1:0] req;
  logic [1:0] field [NUM_SRC];
  logic [1:0] core_mask;
  logic win_valid;
  logic [4:0] win_src;
  logic [1:0] win_level;
  logic blocked;
  logic dropped;
  modport ctrl (output req, field, core_mask, input win_valid, win_src, win_level, blocked,
    dropped);
  modport arb (input req, field, core_mask, output win_valid, win_src, win_level, blocked,
    dropped);
endinterface

// ### rtl/prio_arbiter.sv
// picks the highest-level permitted request
`timescale 1ns/1ps
module prio_arbiter
  import irq_prio_pkg::*;
(
  arb_if.arb arb
);

  // ----------------------------------------------------------------
  // search, lowest index wins a tie
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] dec;
    dec = 3'h0;
    arb.win_valid = 1'b0;
    arb.win_src = 5'h00;
    arb.win_level = 2'h0;
    arb.blocked = 1'b0;
    arb.dropped = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      dec = field_decode(arb.field[i], i < NUM_DBG);
      if (arb.req[i] && !dec[2]) begin
        arb.dropped = 1'b1;
      end else if (arb.req[i] && dec[1:0] < arb.core_mask) begin
        arb.blocked = 1'b1;
      end else if (arb.req[i] && (!arb.win_valid || dec[1:0] >= arb.win_level)) begin
        arb.win_valid = 1'b1;
        arb.win_src = 5'(i);
        arb.win_level = dec[1:0];
      end
    end
  end

endmodule

// ### rtl/irq_priority_level_bank.sv
// priority-level register bank with avalon slave and nesting gate
//
// What this block does
// - debug sources decode 01..11 as levels 1..3
// - peripheral sources decode 01..11 as levels 0..2
// - every level field resets to 00
// - reserved bits read zero, ignore writes
// - register 0 holds breakpoint and step fields
// - register 1 holds debug rx, tx, trace
// - register 2 holds flash, pll, voltage, pins
// - register 3 holds ports D-F and can
// - register 4 holds serial and ports A-C
// - register 5 holds decoder, uart, serial0 tx
// - forward only levels the core mask permits
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module irq_priority_level_bank
  import irq_prio_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic [NUM_SRC-1:0] src_req,
  input wire logic [1:0] core_mask,
  output logic nest_valid,
  output logic [4:0] nest_source,
  output logic [1:0] nest_level,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] prio_reg [NUM_PRIO];
  logic [NUM_EV-1:0] ev_status;
  logic [NUM_EV-1:0] ev_mask;
  logic [5:0] idx;
  logic bus_req;
  logic take;
  logic [15:0] lane_mask;
  logic [NUM_EV-1:0] events;
  logic [NUM_EV-1:0] next_status;
  logic status_clr;

  arb_if arb ();

  prio_arbiter u_arb (
    .arb(arb)
  );

  assign idx = avs_address[ADDR_W-1:2];
  assign bus_req = avs_read | avs_write;
  assign take = bus_req & ~avs_waitrequest;
  assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  function automatic logic mapped(input logic [5:0] i);
    if (i < 6'(NUM_PRIO)) begin
      return 1'b1;
    end else if (i == IDX_STATUS || i == IDX_MASK || i == IDX_ACTIVE) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // ----------------------------------------------------------------
  // field fan-out to arbiter
  // ----------------------------------------------------------------
  assign arb.req = src_req;
  assign arb.core_mask = core_mask;
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    assign arb.field[i] = prio_reg[SRC_REG[i]][2 * SRC_SLOT[i] +: 2];
  end

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, then answer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= RESP_OKAY;
    end else if (bus_req && avs_waitrequest) begin
      avs_response <= mapped(idx) ? RESP_OKAY : RESP_SLVERR;
      avs_readdata <= 32'h0000_0000;
      if (avs_read) begin
        if (idx < 6'(NUM_PRIO)) begin
          avs_readdata <= {16'h0000, prio_reg[idx[2:0]] & IMPL_MASK[idx[2:0]]};
        end else if (idx == IDX_STATUS) begin
          avs_readdata <= {29'h0, ev_status};
        end else if (idx == IDX_MASK) begin
          avs_readdata <= {29'h0, ev_mask};
        end else if (idx == IDX_ACTIVE) begin
          avs_readdata <= {24'h0, nest_valid, nest_source, nest_level};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // priority registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int k = 0; k < NUM_PRIO; k++) begin
        prio_reg[k] <= PRIO_RESET;
      end
    end else if (take && avs_write && idx < 6'(NUM_PRIO)) begin
      prio_reg[idx[2:0]] <= ((prio_reg[idx[2:0]] & ~lane_mask)
        | (avs_writedata[15:0] & lane_mask)) & IMPL_MASK[idx[2:0]];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  assign events = {arb.dropped, arb.blocked, arb.win_valid};
  assign status_clr = take && avs_read && idx == IDX_STATUS;

  always_comb begin
    next_status = ev_status;
    if (status_clr) begin
      next_status = '0;
    end
    next_status = next_status | events;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ev_status <= EV_RESET;
    end else begin
      ev_status <= next_status;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ev_mask <= EV_RESET;
    end else if (take && avs_write && idx == IDX_MASK && avs_byteenable[0]) begin
      ev_mask <= avs_writedata[NUM_EV-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & ev_mask);
    end
  end

  // ----------------------------------------------------------------
  // nesting request to core
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      nest_valid <= 1'b0;
      nest_source <= 5'h00;
      nest_level <= 2'h0;
    end else begin
      nest_valid <= arb.win_valid;
      nest_source <= arb.win_src;
      nest_level <= arb.win_level;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic reserved_set;
  always_comb begin
    reserved_set = 1'b0;
    for (int k = 0; k < NUM_PRIO; k++) begin
      reserved_set = reserved_set | (|(prio_reg[k] & ~IMPL_MASK[k]));
    end
  end

  sequence full_write(logic [5:0] r);
    take && avs_write && idx == r && avs_byteenable[1:0] == 2'h3;
  endsequence

  reset_clear_a: assert property ($fell(rst) |-> prio_reg[0] == 16'h0000
    && prio_reg[2] == 16'h0000 && prio_reg[5] == 16'h0000)
    else $error("level field not cleared by reset");
  reserved_zero_a: assert property (!reserved_set)
    else $error("reserved bit holds a one");
  reg0_layout_a: assert property (full_write(IDX_PRIO0) |=>
    prio_reg[0] == ($past(avs_writedata[15:0]) & 16'h3C00))
    else $error("register 0 layout wrong");
  reg1_layout_a: assert property (full_write(IDX_PRIO1) |=>
    prio_reg[1] == ($past(avs_writedata[15:0]) & 16'h003F))
    else $error("register 1 layout wrong");
  reg2_layout_a: assert property (full_write(IDX_PRIO2) |=>
    prio_reg[2] == ($past(avs_writedata[15:0]) & 16'hFFCF))
    else $error("register 2 layout wrong");
  reg3_layout_a: assert property (full_write(IDX_PRIO3) |=>
    prio_reg[3] == ($past(avs_writedata[15:0]) & 16'hFFFC))
    else $error("register 3 layout wrong");
  reg4_layout_a: assert property (full_write(IDX_PRIO4) |=>
    prio_reg[4] == ($past(avs_writedata[15:0]) & 16'hFC3F))
    else $error("register 4 layout wrong");
  reg5_layout_a: assert property (full_write(IDX_PRIO5) |=>
    prio_reg[5] == ($past(avs_writedata[15:0]) & 16'hFF3F))
    else $error("register 5 layout wrong");
  debug_level_a: assert property (arb.win_valid && arb.win_src < 5'(NUM_DBG) |=>
    nest_level == $past(arb.field[arb.win_src]) && nest_level != 2'h0)
    else $error("debug level decode wrong");
  periph_level_a: assert property (arb.win_valid && arb.win_src >= 5'(NUM_DBG) |->
    arb.win_level == 2'(arb.field[arb.win_src] - 2'h1) && arb.win_level != 2'h3)
    else $error("peripheral level decode wrong");
  mask_gate_a: assert property (nest_valid |-> nest_level >= $past(core_mask))
    else $error("forwarded level below core mask");
  disabled_src_a: assert property (arb.win_valid |-> arb.field[arb.win_src] != 2'h0)
    else $error("disabled source won arbitration");
  readback_a: assert property (full_write(IDX_PRIO3) ##[1:3] (avs_read && idx == IDX_PRIO3
    && avs_waitrequest) |=> avs_readdata[15:0] == prio_reg[3])
    else $error("level field read back wrong");
  status_set_a: assert property (|events |=> |ev_status)
    else $error("event lost in status");

  // ----------------------------------------------------------------
  // bus and interrupt checks
  // ----------------------------------------------------------------
  sequence bus_take;
    bus_req && avs_waitrequest;
  endsequence

  sequence status_read;
    take && avs_read && idx == IDX_STATUS;
  endsequence

  one_wait_a: assert property (bus_take |=> !avs_waitrequest)
    else $error("wait cycle not ended");
  wait_return_a: assert property (take |=> avs_waitrequest)
    else $error("waitrequest not raised after transfer");
  idle_wait_a: assert property (!bus_req |=> avs_waitrequest)
    else $error("waitrequest low while idle");
  readdata_hold_a: assert property (!bus_req |=> $stable(avs_readdata) && $stable(avs_response))
    else $error("read answer changed while idle");
  upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  unmapped_err_a: assert property (bus_take ##0 (!mapped(idx)) |=>
    avs_response == RESP_SLVERR && avs_readdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (bus_take ##0 mapped(idx) |=> avs_response == RESP_OKAY)
    else $error("mapped access refused");
  active_read_a: assert property (bus_take ##0 (avs_read && idx == IDX_ACTIVE) |=>
    avs_readdata[7:0] == {$past(nest_valid), $past(nest_source), $past(nest_level)})
    else $error("active register read wrong");
  lane_keep_a: assert property (take && avs_write && idx == IDX_PRIO2
    && !avs_byteenable[1] |=> prio_reg[2][15:8] == $past(prio_reg[2][15:8]))
    else $error("disabled byte lane written");

  status_clear_a: assert property (status_read ##0 (events == 3'h0) |=> ev_status == 3'h0)
    else $error("status not cleared by read");
  set_wins_a: assert property (status_read ##0 (events != 3'h0) |=>
    (ev_status & $past(events)) == $past(events))
    else $error("event lost in clearing read");
  status_hold_a: assert property (!status_clr && events == 3'h0 |=>
    ev_status == $past(ev_status))
    else $error("status bit changed without cause");
  mask_write_a: assert property (take && avs_write && idx == IDX_MASK && avs_byteenable[0] |=>
    ev_mask == $past(avs_writedata[NUM_EV-1:0]))
    else $error("mask register write wrong");
  irq_level_a: assert property (irq == |(ev_status & $past(ev_mask)))
    else $error("interrupt level wrong");

  reset_outputs_a: assert property ($fell(rst) |-> !nest_valid && !irq && avs_waitrequest)
    else $error("outputs not idle after reset");
  no_request_a: assert property (src_req == 32'h0000_0000 |=> !nest_valid)
    else $error("forward without any request");
  debug_floor_a: assert property (nest_valid && nest_source < 5'(NUM_DBG) |->
    nest_level != 2'h0)
    else $error("debug source below level 1");
  periph_cap_a: assert property (nest_valid && nest_source >= 5'(NUM_DBG) |->
    nest_level != 2'h3)
    else $error("peripheral source at level 3");

endmodule

// ### verif/core_periph_model.sv
// far-side model: core mask and peripheral request lines
`timescale 1ns/1ps
module core_periph_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] want_req,
  input wire logic [1:0] want_mask,
  output logic [31:0] src_req,
  output logic [1:0] core_mask
);
  // ----------------------------------------------------------------
  // request and mask launch on the rising edge
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_req <= 32'h00000000;
      core_mask <= 2'h0;
    end else begin
      src_req <= want_req;
      core_mask <= want_mask;
    end
  end
endmodule

// ### verif/test_irq_priority_level_bank.sv
// self-checking bench for the priority-level bank
`timescale 1ns/1ps
module test_irq_priority_level_bank;
  import irq_prio_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic [31:0] src_req;
  logic [1:0] core_mask;
  logic nest_valid;
  logic [4:0] nest_source;
  logic [1:0] nest_level;
  logic irq;
  logic [31:0] want_req = 32'h00000000;
  logic [1:0] want_mask = 2'h0;
  logic [31:0] rd;
  logic [1:0] rs;
  int bad_count = 0;
  int checks = 0;
  int model_reg [6];
  int impl [6] = '{32'h3C00, 32'h003F, 32'hFFCF, 32'hFFFC, 32'hFC3F, 32'hFF3F};
  int lsb [32] = '{12, 10, 4, 2, 0, 14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2,
                   14, 12, 10, 4, 2, 0, 14, 12, 10, 8, 4, 2, 0};
  always #4 core_clk = ~core_clk;
  irq_priority_level_bank dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .src_req(src_req),
    .core_mask(core_mask), .nest_valid(nest_valid), .nest_source(nest_source),
    .nest_level(nest_level), .irq(irq));
  core_periph_model far (.core_clk(core_clk), .rst(rst), .want_req(want_req),
    .want_mask(want_mask), .src_req(src_req), .core_mask(core_mask));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rs = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (wr && a[7:2] < 6) begin
      model_reg[a[7:2]] = d & impl[a[7:2]];
    end
  endtask
  function automatic int reg_of(input int i);
    return (i < 2) ? 0 : (i < 5) ? 1 : (i < 12) ? 2 : (i < 19) ? 3 : (i < 25) ? 4 : 5;
  endfunction
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    int f, lv, m, k;
    void'($urandom(32'h296d3a65));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    chk(avs_waitrequest, 1'b1);
    chk({nest_valid, irq}, 2'b00);
    for (k = 0; k < 6; k++) begin
      bus(1'b0, 8'(k * 4), 16'h0000);
      chk(rd, 32'h0);
      model_reg[k] = 0;
    end
    $display("test reset values done");
    for (k = 0; k < 6; k++) begin
      bus(1'b1, 8'(k * 4), 16'($urandom));
      bus(1'b0, 8'(k * 4), 16'h0000);
      chk(rd, 32'(model_reg[k]));
    end
    bus(1'b0, 8'h3C, 16'h0000);
    chk(rd, 32'h0);
    chk(rs, RESP_SLVERR);
    $display("test readback done");
    for (int i = 0; i < 32; i++) begin
      f = $urandom_range(3, 0);
      m = $urandom_range(3, 0);
      bus(1'b1, 8'(reg_of(i) * 4), 16'(f << lsb[i]));
      want_req <= 32'h1 << i;
      want_mask <= 2'(m);
      settle();
      lv = (i < NUM_DBG) ? f : f - 1;
      chk(nest_valid, (f != 0 && lv >= m));
      if (f != 0 && lv >= m) begin
        chk({nest_source, nest_level}, {5'(i), 2'(lv)});
      end
      want_req <= 32'h0;
    end
    $display("test decode and gate done");
    want_mask <= 2'h0;
    bus(1'b1, 8'h08, 16'hAA8A);
    bus(1'b1, 8'h14, 16'h0003);
    want_req <= 32'h80000060;
    settle();
    chk({nest_valid, nest_source, nest_level}, {1'b1, 5'd31, 2'd2});
    want_req <= 32'h00000060;
    settle();
    chk({nest_valid, nest_source, nest_level}, {1'b1, 5'd5, 2'd1});
    bus(1'b0, 8'h28, 16'h0000);
    chk(rd, 32'h00000095);
    $display("test arbitration done");
    bus(1'b1, 8'h24, 16'h0001);
    bus(1'b0, 8'h24, 16'h0000);
    chk(rd, 32'h1);
    settle();
    chk(irq, 1'b1);
    bus(1'b0, 8'h20, 16'h0000);
    bus(1'b0, 8'h20, 16'h0000);
    chk(rd, 32'h1);
    want_req <= 32'h0;
    settle();
    bus(1'b0, 8'h20, 16'h0000);
    bus(1'b0, 8'h20, 16'h0000);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    want_mask <= 2'h3;
    want_req <= 32'h00000020;
    settle();
    bus(1'b0, 8'h20, 16'h0000);
    chk({rd[1:0], nest_valid, irq}, 4'b1000);
    $display("test interrupt done");
    avs_byteenable <= 4'h1;
    bus(1'b1, 8'h08, 16'hFFFF);
    avs_byteenable <= 4'hF;
    bus(1'b0, 8'h08, 16'h0000);
    chk(rd, 32'h0000AACF);
    $display("test byte lanes done");
    end_sim();
  end
endmodule
